/* File: design/adc_seq_defines.vh */
`ifndef ADC_SEQ_DEFINES_VH
`define ADC_SEQ_DEFINES_VH

// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define IDX_WRAP_TRIG   6'h00
`define IDX_SEQ_CONFIG  6'h03
`define IDX_TIMING      6'h04
`define IDX_START       6'h05
`define IDX_STATUS      6'h08

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TIM_SAMPLE_MSB  7
`define TIM_SAMPLE_LSB  5
`define TIM_DIV_MSB     4
`define TIM_DIV_LSB     0
`define ST_SPECIAL      6
`define ST_SCAN         5
`define ST_SWEEP        4
`define ST_CODE_MSB     3
`define ST_CODE_LSB     0
`define CFG_LEN_MSB     6
`define CFG_LEN_LSB     3
`define CFG_HALT_MSB    1
`define CFG_HALT_LSB    0
`define WT_ETRIG        7
`define WT_WRAP_MSB     3
`define WT_WRAP_LSB     0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TIMING_RST      8'h00
`define START_RST       8'h00
`define SEQ_CONFIG_RST  8'h20
`define WRAP_TRIG_RST   8'h0f

// ----------------------------------------
// Codes and counts
// ----------------------------------------
`define HALT_RUN        2'b00
`define HALT_FINISH     2'b10
`define HALT_IMMED      2'b11
`define SEQ_LEN_MAX     4'hc
`define INPUT_MAX       4'hb
`define CH_LATE_WRAP    4'h7
`define SRC_INT17       5'h11
`define SRC_VRH         5'h14
`define SRC_VRL         5'h15
`define SRC_VMID        5'h16

`endif

/* File: design/conv_clock_gen.v */
`include "adc_seq_defines.vh"

// ----------------------------------------
// Conversion clock divider
// ----------------------------------------
module conv_clock_gen #(
  parameter PRS_W = 5
) (
  // Clock and reset
  input  wire             pclk,
  input  wire             presetn,
  // Control
  input  wire [PRS_W-1:0] clock_divider,
  input  wire             restart,
  // Conversion clock
  output reg              conv_clk_r,
  output reg              conv_tick_r
);

  reg [PRS_W-1:0] cnt_r;

  // Half period is divider+1 bus cycles; restart realigns phase on abort
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r       <= {PRS_W{1'b0}};
      conv_clk_r  <= 1'b0;
      conv_tick_r <= 1'b0;
    end else if (restart) begin
      cnt_r       <= {PRS_W{1'b0}};
      conv_clk_r  <= 1'b0;
      conv_tick_r <= 1'b0;
    end else if (cnt_r == clock_divider) begin
      cnt_r       <= {PRS_W{1'b0}};
      conv_clk_r  <= ~conv_clk_r;
      conv_tick_r <= ~conv_clk_r; // Pulse on rising edge
    end else begin
      cnt_r       <= cnt_r + 1'b1;
      conv_tick_r <= 1'b0;
    end
  end

endmodule

/* File: design/channel_decode.v */
`include "adc_seq_defines.vh"

// ----------------------------------------
// Input select code to source decode
// ----------------------------------------
module channel_decode (
  // Selection
  input  wire       special_select,
  input  wire [3:0] input_select_code,
  // Decoded source
  output reg  [4:0] source_id,
  output reg        source_reserved
);

  // Reserved codes still drive a source id so the mux never floats
  always @* begin
    source_id       = 5'h00;
    source_reserved = 1'b0;
    if (!special_select) begin
      if (input_select_code > `INPUT_MAX)
        source_id = {1'b0, `INPUT_MAX};
      else
        source_id = {1'b0, input_select_code};
    end else begin
      case (input_select_code)
        4'h1:    source_id = `SRC_INT17;
        4'h4:    source_id = `SRC_VRH;
        4'h5:    source_id = `SRC_VRL;
        4'h6:    source_id = `SRC_VMID;
        default: source_reserved = 1'b1;
      endcase
    end
  end

endmodule

/* File: design/adc_seq_control.v */
// What this block does
// - Debug halt: 00 runs, 10 finishes conversion then halts, 11 halts now.
// - Writing the timing register aborts the running sequence.
// - Sample length code 0..7 gives 4,6,8,10,12,16,20,24 conversion clocks.
// - Conversion clock is bus clock over two times divider plus one.
// - Writing the start register aborts and starts afresh with new settings.
// - With external trigger, one start write arms; each trigger starts a sequence.
// - A conversion starts when its sampling phase begins.
// - Special select bit maps the code onto internal sources.
// - Scan bit: zero runs one sequence, one repeats continuously.
// - External trigger ignores scan; each trigger runs exactly one sequence.
// - Without sweep, every sample uses the selected channel.
// - With sweep, start at selected channel, step once per conversion.
// - Sweep wraps to channel 0 after rollover channel, or first after 7.
// - Normal codes pick inputs 0..11; codes above 11 pick input 11.
// - Special codes: 1 internal 17, 4 high, 5 low, 6 midpoint ref.
// - Length codes 1..11 as given, others 12; reset length is 4.
// - Two debug halt bits sit in bits 1..0 of a control register.
`include "adc_seq_defines.vh"

module adc_seq_control #(
  parameter AW = 8
) (
  // Clock and reset
  input  wire          pclk,
  input  wire          presetn,
  // APB slave
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [AW-1:0] paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata_r,
  output reg           pready_r,
  output reg           pslverr_r,
  // Pins
  input  wire          debug_freeze,
  input  wire          ext_trigger,
  // Analog core
  input  wire          convert_done,
  output wire          conv_clk,
  output reg           sample_active_r,
  output reg           convert_active_r,
  output reg           conv_start_r,
  output reg  [4:0]    source_sel_r,
  output reg           source_reserved_r,
  output reg           core_hold_r,
  output reg           seq_done_r
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam ST_IDLE    = 2'd0;
  localparam ST_SAMPLE  = 2'd1;
  localparam ST_CONVERT = 2'd2;
  localparam ST_GAP     = 2'd3;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function reg_valid;
    input [5:0] idx;
    begin
      reg_valid = (idx == `IDX_WRAP_TRIG) || (idx == `IDX_SEQ_CONFIG) ||
                  (idx == `IDX_TIMING) || (idx == `IDX_START) ||
                  (idx == `IDX_STATUS);
    end
  endfunction

  function [4:0] sample_clocks;
    input [2:0] code;
    begin
      case (code)
        3'd0:    sample_clocks = 5'd4;
        3'd1:    sample_clocks = 5'd6;
        3'd2:    sample_clocks = 5'd8;
        3'd3:    sample_clocks = 5'd10;
        3'd4:    sample_clocks = 5'd12;
        3'd5:    sample_clocks = 5'd16;
        3'd6:    sample_clocks = 5'd20;
        default: sample_clocks = 5'd24;
      endcase
    end
  endfunction

  function [3:0] seq_len;
    input [3:0] code;
    begin
      if (code == 4'h0 || code >= `SEQ_LEN_MAX)
        seq_len = `SEQ_LEN_MAX;
      else
        seq_len = code;
    end
  endfunction

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  reg  [7:0] timing_r;
  reg  [7:0] start_r;
  reg  [7:0] seq_config_r;
  reg  [7:0] wrap_trig_r;
  reg  [1:0] state_r;
  reg  [3:0] cur_ch_r;
  reg  [3:0] first_ch_r;
  reg        wrapped_r;
  reg  [3:0] conv_cnt_r;
  reg  [4:0] samp_cnt_r;
  reg        armed_r;
  reg        dbg_s1_r;
  reg        dbg_s2_r;
  reg        trg_s1_r;
  reg        trg_s2_r;
  reg        trg_d_r;
  wire       conv_tick;
  wire [4:0] src_id;
  wire       src_rsv;

  wire [5:0] idx      = paddr[7:2];
  wire       wr_acc   = psel & penable & pwrite & pready_r;
  wire       hit      = reg_valid(idx);
  wire       wr_tim   = wr_acc & (idx == `IDX_TIMING);
  wire       wr_start = wr_acc & (idx == `IDX_START);
  wire       etrig    = wrap_trig_r[`WT_ETRIG];
  wire [3:0] rollover = wrap_trig_r[`WT_WRAP_MSB:`WT_WRAP_LSB];
  wire [1:0] halt_sel = seq_config_r[`CFG_HALT_MSB:`CFG_HALT_LSB];
  wire [3:0] len      = seq_len(seq_config_r[`CFG_LEN_MSB:`CFG_LEN_LSB]);
  wire [4:0] samp_len = sample_clocks(timing_r[`TIM_SAMPLE_MSB:`TIM_SAMPLE_LSB]);
  wire       trg_edge = trg_s2_r & ~trg_d_r;
  // Mode 01 is reserved and behaves as run
  wire       halt_now = dbg_s2_r & (halt_sel == `HALT_IMMED);
  wire       halt_gap = dbg_s2_r & ((halt_sel == `HALT_IMMED) |
                                    (halt_sel == `HALT_FINISH));
  wire       busy     = (state_r != ST_IDLE);
  // Late wrap point applies only before the first wrap of the sweep
  wire [3:0] wrap_pt  = ((first_ch_r > rollover) && !wrapped_r) ?
                        `CH_LATE_WRAP : rollover;
  wire [3:0] ch_step  = (cur_ch_r == wrap_pt) ? 4'h0 : cur_ch_r + 4'h1;
  wire [3:0] ch_next  = start_r[`ST_SWEEP] ? ch_step : cur_ch_r;

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  conv_clock_gen #(
    .PRS_W (5)
  ) u_clk (
    .pclk          (pclk),
    .presetn       (presetn),
    .clock_divider (timing_r[`TIM_DIV_MSB:`TIM_DIV_LSB]),
    .restart       (wr_tim | wr_start),
    .conv_clk_r    (conv_clk),
    .conv_tick_r   (conv_tick)
  );

  channel_decode u_dec (
    .special_select    (start_r[`ST_SPECIAL]),
    .input_select_code (cur_ch_r),
    .source_id         (src_id),
    .source_reserved   (src_rsv)
  );

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Two flops each; edge detect compares the second stage with its delayed copy trg_d_r
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbg_s1_r <= 1'b0;
      dbg_s2_r <= 1'b0;
      trg_s1_r <= 1'b0;
      trg_s2_r <= 1'b0;
      trg_d_r  <= 1'b0;
    end else begin
      dbg_s1_r <= debug_freeze;
      dbg_s2_r <= dbg_s1_r;
      trg_s1_r <= ext_trigger;
      trg_s2_r <= trg_s1_r;
      trg_d_r  <= trg_s2_r;
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // One wait-free access phase; ready is raised for the access cycle only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= psel & ~penable & ~pready_r;
      pslverr_r <= psel & ~penable & ~hit;
      prdata_r  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        case (idx)
          `IDX_WRAP_TRIG:  prdata_r <= {24'h000000, wrap_trig_r};
          `IDX_SEQ_CONFIG: prdata_r <= {24'h000000, seq_config_r};
          `IDX_TIMING:     prdata_r <= {24'h000000, timing_r};
          `IDX_START:      prdata_r <= {24'h000000, start_r};
          `IDX_STATUS:     prdata_r <= {21'h0, halt_now & busy,
                                        armed_r, busy, conv_cnt_r, cur_ch_r};
          default:         prdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Register writes land at the access edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timing_r     <= `TIMING_RST;
      start_r      <= `START_RST;
      seq_config_r <= `SEQ_CONFIG_RST;
      wrap_trig_r  <= `WRAP_TRIG_RST;
    end else if (wr_acc) begin
      case (idx)
        `IDX_WRAP_TRIG:  wrap_trig_r  <= pwdata[7:0];
        `IDX_SEQ_CONFIG: seq_config_r <= {1'b0, pwdata[6:0]};
        `IDX_TIMING:     timing_r     <= pwdata[7:0];
        `IDX_START:      start_r      <= {1'b0, pwdata[6:0]};
        default:         timing_r     <= timing_r;
      endcase
    end
  end

  // ----------------------------------------
  // Source select to the core
  // ----------------------------------------
  // Registered decode trails a channel change by one bus cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      source_sel_r      <= 5'h00;
      source_reserved_r <= 1'b0;
      core_hold_r       <= 1'b0;
    end else begin
      source_sel_r      <= src_id;
      source_reserved_r <= src_rsv;
      core_hold_r       <= halt_now & busy;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Aborts take priority over any progress in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r          <= ST_IDLE;
      cur_ch_r         <= 4'h0;
      first_ch_r       <= 4'h0;
      wrapped_r        <= 1'b0;
      conv_cnt_r       <= 4'h0;
      samp_cnt_r       <= 5'h00;
      armed_r          <= 1'b0;
      sample_active_r  <= 1'b0;
      convert_active_r <= 1'b0;
      conv_start_r     <= 1'b0;
      seq_done_r       <= 1'b0;
    end else begin
      conv_start_r <= 1'b0;
      seq_done_r   <= 1'b0;
      if (wr_start) begin
        // New settings come straight from the write data
        state_r          <= ST_SAMPLE;
        cur_ch_r         <= pwdata[`ST_CODE_MSB:`ST_CODE_LSB];
        first_ch_r       <= pwdata[`ST_CODE_MSB:`ST_CODE_LSB];
        wrapped_r        <= 1'b0;
        conv_cnt_r       <= 4'h0;
        samp_cnt_r       <= 5'h00;
        armed_r          <= 1'b1;
        sample_active_r  <= 1'b1;
        convert_active_r <= 1'b0;
        conv_start_r     <= 1'b1;
      end else if (wr_tim) begin
        state_r          <= ST_IDLE;
        sample_active_r  <= 1'b0;
        convert_active_r <= 1'b0;
        conv_cnt_r       <= 4'h0;
      end else begin
        case (state_r)
          ST_IDLE: begin
            // Triggers are only honoured once armed by a start write
            if (etrig && armed_r && trg_edge) begin
              state_r         <= ST_SAMPLE;
              cur_ch_r        <= first_ch_r;
              wrapped_r       <= 1'b0;
              conv_cnt_r      <= 4'h0;
              samp_cnt_r      <= 5'h00;
              sample_active_r <= 1'b1;
              conv_start_r    <= 1'b1;
            end
          end
          ST_SAMPLE: begin
            if (conv_tick && !halt_now) begin
              if (samp_cnt_r == samp_len - 5'd1) begin
                state_r          <= ST_CONVERT;
                sample_active_r  <= 1'b0;
                convert_active_r <= 1'b1;
              end else begin
                samp_cnt_r <= samp_cnt_r + 5'd1;
              end
            end
          end
          ST_CONVERT: begin
            if (convert_done && !halt_now) begin
              convert_active_r <= 1'b0;
              if (conv_cnt_r == len - 4'h1) begin
                seq_done_r <= 1'b1;
                // Triggered runs are single; scan repeats from first channel
                if (start_r[`ST_SCAN] && !etrig) begin
                  state_r    <= ST_GAP;
                  cur_ch_r   <= first_ch_r;
                  wrapped_r  <= 1'b0;
                  conv_cnt_r <= 4'h0;
                end else begin
                  state_r <= ST_IDLE;
                end
              end else begin
                state_r    <= ST_GAP;
                conv_cnt_r <= conv_cnt_r + 4'h1;
                cur_ch_r   <= ch_next;
                if (start_r[`ST_SWEEP] && ch_step == 4'h0)
                  wrapped_r <= 1'b1;
              end
            end
          end
          ST_GAP: begin
            // Halt between conversions for both freezing modes
            if (!halt_gap) begin
              state_r         <= ST_SAMPLE;
              samp_cnt_r      <= 5'h00;
              sample_active_r <= 1'b1;
              conv_start_r    <= 1'b1;
            end
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule

/* File: test/analog_core_model.sv */
// ----------------------------------------
// Analog core stand-in
// ----------------------------------------
module analog_core_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // From sequencer
  input wire logic convert_active_r,
  input wire logic core_hold_r,
  // Bench control
  input wire logic slow,
  // To sequencer
  output logic     convert_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;

  // One done pulse per phase; a frozen core does not advance
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      convert_done <= 1'b0;
    end else begin
      convert_done <= 1'b0;
      if (!convert_active_r) cnt <= 0;
      else if (!core_hold_r && cnt <= 12) begin
        cnt <= cnt + 1;
        if (cnt == (slow ? 12 : 2)) convert_done <= 1'b1;
      end
    end
  end
endmodule

/* File: test/adc_seq_checker.sv */
module adc_seq_checker #(
  parameter AW = 8
) (
  // Clock and reset
  input wire logic          pclk,
  input wire logic          presetn,
  // APB
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0]   pwdata,
  input wire logic [31:0]   prdata_r,
  input wire logic          pready_r,
  input wire logic          pslverr_r,
  // Pins and core
  input wire logic          debug_freeze,
  input wire logic          ext_trigger,
  input wire logic          convert_done,
  input wire logic          conv_clk,
  input wire logic          sample_active_r,
  input wire logic          convert_active_r,
  input wire logic          conv_start_r,
  input wire logic [4:0]    source_sel_r,
  input wire logic          source_reserved_r,
  input wire logic          core_hold_r,
  input wire logic          seq_done_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic mapped;

  // Decoded register indices
  assign mapped = paddr[7:2] inside {6'h00, 6'h03, 6'h04, 6'h05, 6'h08};

  // ----------------------------------------
  // Bus steps
  // ----------------------------------------
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wr(idx);
    psel && penable && pwrite && pready_r && paddr[7:2] == idx;
  endsequence

  AST_PREADY_NEXT: assert property (s_setup |=> pready_r) else $error("no ready after setup");
  AST_PREADY_ONE: assert property (pready_r |=> !pready_r) else $error("ready held too long");
  AST_SLVERR: assert property (s_setup ##0 !mapped |=> pslverr_r && prdata_r == 32'h0)
    else $error("unmapped access not refused");
  AST_IDLE_ZERO: assert property (!pready_r |-> prdata_r == 32'h0) else $error("read data outside access");
  AST_START_NOW: assert property (s_wr(6'h05) |=> conv_start_r && sample_active_r)
    else $error("start write did not start");
  AST_TIMING_ABORT: assert property (s_wr(6'h04) |=> (!sample_active_r && !convert_active_r)[*2])
    else $error("timing write did not abort");
  AST_START_SAMPLES: assert property (conv_start_r |-> sample_active_r)
    else $error("start without sampling");
  AST_PHASE_EXCL: assert property (!(sample_active_r && convert_active_r)) else $error("phases overlap");
  AST_DONE_ENDS: assert property (!debug_freeze[*3] ##0 (convert_active_r && convert_done && !psel)
    |=> !convert_active_r) else $error("done did not end phase");
  AST_HOLD_STILL: assert property ((core_hold_r && !psel) ##1 core_hold_r
    |-> $stable(sample_active_r) && $stable(convert_active_r) && !conv_start_r)
    else $error("halted core moved");
  AST_SEQ_DONE: assert property (seq_done_r |-> $past(convert_done))
    else $error("sequence end without done");
endmodule

bind adc_seq_control adc_seq_checker #(.AW(AW)) adc_seq_checker_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r), .pready_r(pready_r),
  .pslverr_r(pslverr_r), .debug_freeze(debug_freeze), .ext_trigger(ext_trigger),
  .convert_done(convert_done), .conv_clk(conv_clk), .sample_active_r(sample_active_r),
  .convert_active_r(convert_active_r), .conv_start_r(conv_start_r), .source_sel_r(source_sel_r),
  .source_reserved_r(source_reserved_r), .core_hold_r(core_hold_r), .seq_done_r(seq_done_r));

/* File: test/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
  logic        pclk, presetn, psel, penable, pwrite, debug_freeze, ext_trigger, slow;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata_r;
  logic        pready_r, pslverr_r, convert_done, conv_clk, sample_active_r, convert_active_r;
  logic        conv_start_r, source_reserved_r, core_hold_r, seq_done_r, ok;
  logic [4:0]  source_sel_r;
  logic [4:0]  exp_q[$];
  int          num_errors, compares, c;

  adc_seq_control adc_seq_control_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r), .pready_r(pready_r),
    .pslverr_r(pslverr_r), .debug_freeze(debug_freeze), .ext_trigger(ext_trigger),
    .convert_done(convert_done), .conv_clk(conv_clk), .sample_active_r(sample_active_r),
    .convert_active_r(convert_active_r), .conv_start_r(conv_start_r), .source_sel_r(source_sel_r),
    .source_reserved_r(source_reserved_r), .core_hold_r(core_hold_r), .seq_done_r(seq_done_r));
  analog_core_model analog_core_model_i (.pclk(pclk), .presetn(presetn), .convert_active_r(convert_active_r),
    .core_hold_r(core_hold_r), .slow(slow), .convert_done(convert_done));

  // ----------------------------------------
  // Bus and sequence helpers
  // ----------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int t;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (t = 0; t < 50; t++) begin
      @(posedge pclk);
      if (pready_r === 1'b1) break;
    end
    if (t == 50) num_errors++;
    r = prdata_r;
    e = pslverr_r;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r; logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] x, input string n);
    logic [31:0] r; logic e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK(n, x, r)
  endtask
  // Sources seen one cycle after each start, until the sequence ends
  task automatic run_seq(input string n);
    logic [4:0] got[$];
    for (int t = 0; t < 3000; t++) begin
      @(posedge pclk);
      if (conv_start_r === 1'b1) begin @(posedge pclk); got.push_back(source_sel_r); end
      if (seq_done_r === 1'b1) break;
    end
    `CHK(n, exp_q.size(), got.size())
    foreach (exp_q[i]) if (i < got.size()) `CHK(n, exp_q[i], got[i])
  endtask
  task automatic wait_done(output logic f);
    f = 1'b0;
    for (int t = 0; t < 3000 && !f; t++) begin @(posedge pclk); f = (seq_done_r === 1'b1); end
  endtask
  task automatic starts(input int n, output int k);
    k = 0;
    repeat (n) begin @(posedge pclk); if (conv_start_r === 1'b1) k++; end
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin pclk = 1'b0; forever #5 pclk = ~pclk; end
  // Hang guard, far beyond the expected run
  initial begin #900000; num_errors++; conclude; end

  initial begin
    int slen[8] = '{4, 6, 8, 10, 12, 16, 20, 24};
    logic [3:0] lc[3] = '{4'h0, 4'hb, 4'hf};
    int ln[3] = '{12, 11, 12};
    logic [3:0] scode[4] = '{4'h1, 4'h4, 4'h5, 4'h6};
    logic [4:0] sp[4] = '{5'h11, 5'h14, 5'h15, 5'h16};
    logic [4:0] pr; logic cp; int p, n, r1, r2;
    {presetn, psel, penable, pwrite, debug_freeze, ext_trigger, slow} = 7'h0;
    paddr = 8'h0; pwdata = 32'h0; num_errors = 0; compares = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and an unmapped slot
    rchk(8'h10, 32'h0, "timing"); rchk(8'h14, 32'h0, "start");
    rchk(8'h0c, 32'h20, "config");
    rchk(8'h00, 32'h0f, "wrap");
    rchk(8'h3c, 32'h0, "unmapped");
    rchk(8'h20, 32'h0, "status");
    $display("test registers done");
    // Sample length codes, alternating divider 0 and 2
    for (int k = 0; k < 8; k++) begin
      pr = k[0] ? 5'h02 : 5'h00;
      p = 2 * (pr + 1);
      wr(8'h10, {24'h0, k[2:0], pr});
      wr(8'h14, 32'h03);
      n = 0; r1 = -1; r2 = -1; cp = 1'b1;
      for (int t = 0; t < 400; t++) begin
        @(posedge pclk);
        if (sample_active_r === 1'b1) begin
          n++;
          if (conv_clk === 1'b1 && cp === 1'b0) begin if (r1 < 0) r1 = t; else if (r2 < 0) r2 = t; end
        end else if (n > 0) break;
        cp = conv_clk;
      end
      `CHK("sample span", 1'b1, n > (slen[k] - 1) * p && n <= (slen[k] + 1) * p)
      `CHK("clock period", p, r2 - r1)
      wait_done(ok);
    end
    $display("test timing done");
    // Fixed channel and sweeps with wrap on a slow core, then lengths on a fast core
    wr(8'h10, 32'h01); slow <= 1'b1;
    wr(8'h0c, 32'h18); exp_q = '{5'hb, 5'hb, 5'hb}; wr(8'h14, 32'h0d); run_seq("fixed");
    wr(8'h00, 32'h02); wr(8'h0c, 32'h30);
    exp_q = '{5'h6, 5'h7, 5'h0, 5'h1, 5'h2, 5'h0}; wr(8'h14, 32'h16); run_seq("late wrap");
    wr(8'h00, 32'h06); wr(8'h0c, 32'h28);
    exp_q = '{5'h5, 5'h6, 5'h0, 5'h1, 5'h2}; wr(8'h14, 32'h15); run_seq("wrap");
    slow <= 1'b0;
    foreach (lc[i]) begin
      wr(8'h0c, {25'h0, lc[i], 3'h0});
      exp_q = {};
      repeat (ln[i]) exp_q.push_back(5'h02);
      wr(8'h14, 32'h02); run_seq("length");
    end
    $display("test channels done");
    // Special sources and a reserved code
    wr(8'h0c, 32'h08);
    foreach (scode[i]) begin exp_q = '{sp[i]}; wr(8'h14, {28'h4, scode[i]}); run_seq("special"); end
    wr(8'h14, 32'h40); repeat (2) @(posedge pclk);
    `CHK("reserved", 1'b1, source_reserved_r)
    wait_done(ok);
    $display("test special done");
    // Continuous mode, then timing write aborts
    wr(8'h14, 32'h23); wait_done(ok); starts(60, c);
    `CHK("scan repeats", 1'b1, c > 0)
    wr(8'h10, 32'h01); starts(100, c);
    `CHK("aborted", 0, c)
    $display("test scan done");
    // Debug halt modes 11, 10, 00 with length 2
    wr(8'h0c, 32'h13); wr(8'h14, 32'h02);
    repeat (3) @(posedge pclk); debug_freeze <= 1'b1;
    repeat (20) @(posedge pclk);
    `CHK("hold now", 1'b1, core_hold_r)
    debug_freeze <= 1'b0; wait_done(ok);
    `CHK("thawed", 1'b1, ok)
    wr(8'h0c, 32'h12); wr(8'h14, 32'h02);
    repeat (3) @(posedge pclk); debug_freeze <= 1'b1; starts(300, c);
    `CHK("finish then halt", 0, c)
    `CHK("no hold", 1'b0, core_hold_r)
    debug_freeze <= 1'b0; wait_done(ok);
    wr(8'h0c, 32'h10); wr(8'h14, 32'h02); debug_freeze <= 1'b1; wait_done(ok);
    `CHK("runs frozen", 1'b1, ok)
    debug_freeze <= 1'b0;
    $display("test halt done");
    // External trigger: arm, one sequence per trigger, abort back to waiting
    wr(8'h0c, 32'h08); wr(8'h00, 32'h8f); wr(8'h14, 32'h23); wait_done(ok); starts(100, c);
    `CHK("scan ignored", 0, c)
    exp_q = '{5'h3}; ext_trigger <= 1'b1; run_seq("trigger");
    ext_trigger <= 1'b0; starts(100, c);
    `CHK("one per trigger", 0, c)
    ext_trigger <= 1'b1; starts(8, c); wr(8'h10, 32'h01); ext_trigger <= 1'b0; starts(100, c);
    `CHK("idle after abort", 0, c)
    ext_trigger <= 1'b1; run_seq("retrigger");
    ext_trigger <= 1'b0; wr(8'h00, 32'h0f);
    rchk(8'h20, 32'h203, "status armed");
    $display("test trigger done");
    conclude;
  end
endmodule
